// *** rtl/bwa_pkg.sv ***
// Constants, register map and carrier types for the bulk-only wrapper assist.
// Assumes one system clock; the USB engine and APB master share it.
// How it works
// - Per-endpoint enable bit turns assist on
// - Wrappers use dedicated areas, not endpoint FIFO
// - Command run treats OUT data as wrapper
// - Exact 31 bytes: store, done, clear runs
// - Wrong length: discard, length error, clear runs
// - Forced stall on OUT: stall error, clear runs
// - Transaction error: discard, flag, runs kept
// - Firmware reads command area over the bus
// - Status run answers IN with 13 bytes
// - Acked status: done, stop status, start command
// - No ack: flag, keep status, start command
// - Both running: resend status or take command
// - Firmware loads status area over the bus
package bwa_pkg;

	localparam int NUM_EP = 5;
	localparam int EP_IDX_W = 3;
	localparam int FLAG_W = 6;
	localparam int CMD_AREA_BYTES = 32;
	localparam int STATUS_AREA_BYTES = 16;
	localparam logic [5:0] CMD_LEN = 6'h1F;
	localparam logic [5:0] CMD_CNT_MAX = 6'h20;
	localparam logic [3:0] STATUS_LEN = 4'hD;

	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_CONTROL = 8'h04;
	localparam logic [7:0] OFS_FLAGS = 8'h08;
	localparam logic [7:0] OFS_FLAG_EN = 8'h0C;
	localparam logic [7:0] OFS_RAM_INDEX = 8'h10;
	localparam logic [7:0] OFS_CMD_RAM = 8'h14;
	localparam logic [7:0] OFS_STATUS_RAM = 8'h18;
	localparam logic [7:0] OFS_STATE = 8'h1C;

	localparam int CTL_CMD_RUN = 0;
	localparam int CTL_STATUS_RUN = 1;
	localparam int CTL_CMD_EP_LSB = 4;
	localparam int CTL_STATUS_EP_LSB = 8;

	localparam int FLG_CMD_DONE = 0;
	localparam int FLG_CMD_LEN_ERR = 1;
	localparam int FLG_CMD_STALL_ERR = 2;
	localparam int FLG_CMD_XACT_ERR = 3;
	localparam int FLG_STATUS_DONE = 4;
	localparam int FLG_STATUS_NO_ACK = 5;

	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [4:0] CONFIG_RST = 5'h00;
	localparam logic [5:0] FLAGS_RST = 6'h00;

	// Events from the USB serial engine, all one-cycle pulses except ep/data
	typedef struct packed {
		logic out_start;
		logic out_byte;
		logic [7:0] out_data;
		logic out_end;
		logic out_crc_err;
		logic out_stalled;
		logic [EP_IDX_W-1:0] ep;
		logic in_token;
		logic in_byte_taken;
		logic in_acked;
		logic in_no_ack;
	} bwa_sie_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic last;
	} bwa_tx_t;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_SEND = 2'b01,
		TX_WAIT = 2'b10
	} bwa_tx_state_t;

endpackage

// *** rtl/bwa_wrapper_assist.sv ***
// Bulk-only command/status wrapper assist with APB register access.
// Assumes the USB engine runs on CLK_SYS and steers claimed endpoints here.
`timescale 1ns/10ps
`default_nettype none
module bwa_wrapper_assist (
	input wire logic CLK_SYS,
	input wire logic ARST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire bwa_pkg::bwa_sie_t SIE_EV,
	input wire logic [bwa_pkg::NUM_EP-1:0] EP_FORCE_STALL,
	output logic [bwa_pkg::NUM_EP-1:0] OUT_ASSIST_EP,
	output logic [bwa_pkg::NUM_EP-1:0] IN_ASSIST_EP,
	output bwa_pkg::bwa_tx_t IN_TX,
	output logic WRAPPER_EVENT_REQ
);
	import bwa_pkg::*;

	function automatic logic [NUM_EP-1:0] ep_bit(input logic [EP_IDX_W-1:0] idx);
		logic [NUM_EP-1:0] r;
		r = '0;
		for (int i = 0; i < NUM_EP; i++) begin
			if (idx == EP_IDX_W'(i)) begin
				r[i] = 1'b1;
			end
		end
		return r;
	endfunction

	logic [NUM_EP-1:0] ep_wrapper_assist_enable, next_ep_wrapper_assist_enable;
	logic cmd_wrapper_run, next_cmd_wrapper_run;
	logic status_wrapper_run, next_status_wrapper_run;
	logic [EP_IDX_W-1:0] cmd_ep, next_cmd_ep;
	logic [EP_IDX_W-1:0] status_ep, next_status_ep;
	logic [FLAG_W-1:0] wrapper_event_flags, next_wrapper_event_flags;
	logic [FLAG_W-1:0] flag_en, next_flag_en;
	logic [2:0] ram_index, next_ram_index;
	logic [31:0] prdata, next_prdata;
	logic pready, next_pready;
	logic pslverr, next_pslverr;
	logic rx_active, next_rx_active;
	logic [5:0] rx_cnt, next_rx_cnt;
	logic cur_bank, next_cur_bank;
	bwa_tx_state_t tx_state, next_tx_state;
	logic [3:0] tx_idx, next_tx_idx;
	bwa_tx_t tx, next_tx;
	logic [NUM_EP-1:0] out_mask, next_out_mask;
	logic [NUM_EP-1:0] in_mask, next_in_mask;
	logic event_req, next_event_req;

	// Two command banks: reception fills the idle one so a bad packet never
	// disturbs the last good wrapper firmware may still be reading.
	logic [7:0] cmd_mem [2][CMD_AREA_BYTES];
	logic [7:0] status_mem [STATUS_AREA_BYTES];

	logic acc, wr_now;
	logic cmd_claim, in_claim, stall_hit;
	logic [FLAG_W-1:0] flag_set, flag_clr;
	logic store_byte;

	always_comb begin
		acc = PSEL & PENABLE;
		wr_now = acc & pready & PWRITE;
		cmd_claim = cmd_wrapper_run & |(ep_bit(cmd_ep) & ep_wrapper_assist_enable)
			& (SIE_EV.ep == cmd_ep);
		in_claim = status_wrapper_run & |(ep_bit(status_ep) & ep_wrapper_assist_enable)
			& (SIE_EV.ep == status_ep);
		stall_hit = SIE_EV.out_stalled & cmd_claim
			& |(ep_bit(SIE_EV.ep) & EP_FORCE_STALL);
		store_byte = rx_active & SIE_EV.out_byte & (rx_cnt < CMD_CNT_MAX);
	end

	// APB: one wait state so read data leaves a flip-flop
	always_comb begin
		logic mapped;
		mapped = 1'b0;
		next_pready = acc & ~pready;
		next_pslverr = 1'b0;
		next_prdata = prdata;
		case (PADDR)
			OFS_CONFIG, OFS_CONTROL, OFS_FLAGS, OFS_FLAG_EN, OFS_RAM_INDEX,
			OFS_CMD_RAM, OFS_STATUS_RAM, OFS_STATE: begin
				mapped = 1'b1;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
		if (acc && !pready) begin
			next_pslverr = ~mapped;
			next_prdata = WORD_ZERO;
			case (PADDR)
				OFS_CONFIG: begin
					next_prdata[NUM_EP-1:0] = ep_wrapper_assist_enable;
				end
				OFS_CONTROL: begin
					next_prdata[CTL_CMD_RUN] = cmd_wrapper_run;
					next_prdata[CTL_STATUS_RUN] = status_wrapper_run;
					next_prdata[CTL_CMD_EP_LSB +: EP_IDX_W] = cmd_ep;
					next_prdata[CTL_STATUS_EP_LSB +: EP_IDX_W] = status_ep;
				end
				OFS_FLAGS: begin
					next_prdata[FLAG_W-1:0] = wrapper_event_flags;
				end
				OFS_FLAG_EN: begin
					next_prdata[FLAG_W-1:0] = flag_en;
				end
				OFS_RAM_INDEX: begin
					next_prdata[2:0] = ram_index;
				end
				OFS_CMD_RAM: begin
					for (int b = 0; b < 4; b++) begin
						next_prdata[8*b +: 8] = cmd_mem[cur_bank][{ram_index, 2'(b)}];
					end
				end
				OFS_STATUS_RAM: begin
					for (int b = 0; b < 4; b++) begin
						next_prdata[8*b +: 8] = status_mem[{ram_index[1:0], 2'(b)}];
					end
				end
				OFS_STATE: begin
					next_prdata[5:0] = rx_cnt;
					next_prdata[8] = rx_active;
					next_prdata[9] = cur_bank;
					next_prdata[13:12] = tx_state;
					next_prdata[19:16] = tx_idx;
				end
				default: begin
					next_prdata = WORD_ZERO;
				end
			endcase
		end
	end

	// Control, reception, transmission and flags
	always_comb begin
		next_ep_wrapper_assist_enable = ep_wrapper_assist_enable;
		next_cmd_wrapper_run = cmd_wrapper_run;
		next_status_wrapper_run = status_wrapper_run;
		next_cmd_ep = cmd_ep;
		next_status_ep = status_ep;
		next_flag_en = flag_en;
		next_ram_index = ram_index;
		next_rx_active = rx_active;
		next_rx_cnt = rx_cnt;
		next_cur_bank = cur_bank;
		next_tx_state = tx_state;
		next_tx_idx = tx_idx;
		next_tx = tx;
		flag_set = '0;
		flag_clr = '0;

		if (wr_now) begin
			case (PADDR)
				OFS_CONFIG: begin
					next_ep_wrapper_assist_enable = PWDATA[NUM_EP-1:0];
				end
				OFS_CONTROL: begin
					next_cmd_wrapper_run = PWDATA[CTL_CMD_RUN];
					next_status_wrapper_run = PWDATA[CTL_STATUS_RUN];
					next_cmd_ep = PWDATA[CTL_CMD_EP_LSB +: EP_IDX_W];
					next_status_ep = PWDATA[CTL_STATUS_EP_LSB +: EP_IDX_W];
				end
				OFS_FLAGS: begin
					flag_clr = PWDATA[FLAG_W-1:0];
				end
				OFS_FLAG_EN: begin
					next_flag_en = PWDATA[FLAG_W-1:0];
				end
				OFS_RAM_INDEX: begin
					next_ram_index = PWDATA[2:0];
				end
				default: begin
					next_ram_index = ram_index;
				end
			endcase
		end

		// Command wrapper reception; hardware outcome overrides a same-cycle write
		if (SIE_EV.out_start && cmd_claim) begin
			next_rx_active = 1'b1;
			next_rx_cnt = '0;
		end
		if (store_byte) begin
			next_rx_cnt = rx_cnt + 6'h01;
		end
		if (rx_active && SIE_EV.out_end) begin
			next_rx_active = 1'b0;
			if (SIE_EV.out_crc_err) begin
				flag_set[FLG_CMD_XACT_ERR] = 1'b1;
			end else if (rx_cnt == CMD_LEN) begin
				flag_set[FLG_CMD_DONE] = 1'b1;
				next_cur_bank = ~cur_bank;
				next_cmd_wrapper_run = 1'b0;
				next_status_wrapper_run = 1'b0;
			end else begin
				flag_set[FLG_CMD_LEN_ERR] = 1'b1;
				next_cmd_wrapper_run = 1'b0;
				next_status_wrapper_run = 1'b0;
			end
		end
		if (stall_hit) begin
			flag_set[FLG_CMD_STALL_ERR] = 1'b1;
			next_rx_active = 1'b0;
			next_cmd_wrapper_run = 1'b0;
			next_status_wrapper_run = 1'b0;
		end

		// Status wrapper transmission; a repeated IN simply restarts at byte 0
		case (tx_state)
			TX_IDLE: begin
				if (SIE_EV.in_token && in_claim) begin
					next_tx_state = TX_SEND;
					next_tx_idx = '0;
					next_tx.valid = 1'b1;
					next_tx.data = status_mem[0];
					next_tx.last = 1'b0;
				end
			end
			TX_SEND: begin
				if (SIE_EV.in_byte_taken) begin
					if (tx_idx == STATUS_LEN - 4'h1) begin
						next_tx_state = TX_WAIT;
						next_tx.valid = 1'b0;
						next_tx.last = 1'b0;
					end else begin
						next_tx_idx = tx_idx + 4'h1;
						next_tx.data = status_mem[tx_idx + 4'h1];
						next_tx.last = (tx_idx + 4'h1 == STATUS_LEN - 4'h1);
					end
				end
			end
			TX_WAIT: begin
				if (SIE_EV.in_acked) begin
					next_tx_state = TX_IDLE;
					flag_set[FLG_STATUS_DONE] = 1'b1;
					next_status_wrapper_run = 1'b0;
					next_cmd_wrapper_run = 1'b1;
				end else if (SIE_EV.in_no_ack) begin
					next_tx_state = TX_IDLE;
					flag_set[FLG_STATUS_NO_ACK] = 1'b1;
					next_cmd_wrapper_run = 1'b1;
				end
			end
			default: begin
				next_tx_state = TX_IDLE;
				next_tx.valid = 1'b0;
			end
		endcase

		// Set wins over a same-cycle write-one-to-clear
		next_wrapper_event_flags = (wrapper_event_flags & ~flag_clr) | flag_set;
		next_event_req = |(next_wrapper_event_flags & next_flag_en);
		next_out_mask = next_cmd_wrapper_run
			? (ep_bit(next_cmd_ep) & next_ep_wrapper_assist_enable) : '0;
		next_in_mask = next_status_wrapper_run
			? (ep_bit(next_status_ep) & next_ep_wrapper_assist_enable) : '0;
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			ep_wrapper_assist_enable <= CONFIG_RST;
			cmd_wrapper_run <= 1'b0;
			status_wrapper_run <= 1'b0;
			cmd_ep <= '0;
			status_ep <= '0;
			wrapper_event_flags <= FLAGS_RST;
			flag_en <= FLAGS_RST;
			ram_index <= '0;
			prdata <= WORD_ZERO;
			pready <= 1'b0;
			pslverr <= 1'b0;
			rx_active <= 1'b0;
			rx_cnt <= '0;
			cur_bank <= 1'b0;
			tx_state <= TX_IDLE;
			tx_idx <= '0;
			tx <= '0;
			out_mask <= '0;
			in_mask <= '0;
			event_req <= 1'b0;
		end else begin
			ep_wrapper_assist_enable <= next_ep_wrapper_assist_enable;
			cmd_wrapper_run <= next_cmd_wrapper_run;
			status_wrapper_run <= next_status_wrapper_run;
			cmd_ep <= next_cmd_ep;
			status_ep <= next_status_ep;
			wrapper_event_flags <= next_wrapper_event_flags;
			flag_en <= next_flag_en;
			ram_index <= next_ram_index;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			rx_active <= next_rx_active;
			rx_cnt <= next_rx_cnt;
			cur_bank <= next_cur_bank;
			tx_state <= next_tx_state;
			tx_idx <= next_tx_idx;
			tx <= next_tx;
			out_mask <= next_out_mask;
			in_mask <= next_in_mask;
			event_req <= next_event_req;
		end
	end

	// Wrapper memories carry no reset; contents are defined by the writers
	always_ff @(posedge CLK_SYS) begin
		if (store_byte) begin
			cmd_mem[~cur_bank][rx_cnt[4:0]] <= SIE_EV.out_data;
		end
		if (wr_now && PADDR == OFS_STATUS_RAM) begin
			for (int b = 0; b < 4; b++) begin
				status_mem[{ram_index[1:0], 2'(b)}] <= PWDATA[8*b +: 8];
			end
		end
	end

	assign PRDATA = prdata;
	assign PREADY = pready;
	assign PSLVERR = pslverr;
	assign OUT_ASSIST_EP = out_mask;
	assign IN_ASSIST_EP = in_mask;
	assign IN_TX = tx;
	assign WRAPPER_EVENT_REQ = event_req;

endmodule // bwa_wrapper_assist
`default_nettype wire

// *** testbench/bwa_asserts.sv ***
// Port checker for the wrapper assist.
// Assumes one clock domain; bound into bwa_wrapper_assist by the bind below.
`timescale 1ns/10ps
`default_nettype none
module bwa_asserts (
	input wire logic CLK_SYS,
	input wire logic ARST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire bwa_pkg::bwa_sie_t SIE_EV,
	input wire logic [bwa_pkg::NUM_EP-1:0] EP_FORCE_STALL,
	input wire logic [bwa_pkg::NUM_EP-1:0] OUT_ASSIST_EP,
	input wire logic [bwa_pkg::NUM_EP-1:0] IN_ASSIST_EP,
	input wire bwa_pkg::bwa_tx_t IN_TX
);
	import bwa_pkg::*;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!ARST_N);
	// Tracks a claimed command packet, so an unclaimed end is not held to the clear rule
	logic rx_open;
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			rx_open <= 1'b0;
		end else if (SIE_EV.out_start && OUT_ASSIST_EP[SIE_EV.ep]) begin
			rx_open <= 1'b1;
		end else if (SIE_EV.out_end || SIE_EV.out_stalled) begin
			rx_open <= 1'b0;
		end
	end
	a_apb_one_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
		else $error("access not answered");
	a_err_with_ready: assert property (PSLVERR |-> PREADY)
		else $error("error without ready");
	a_assist_onehot: assert property ($onehot0(OUT_ASSIST_EP) && $onehot0(IN_ASSIST_EP))
		else $error("assist not onehot");
	a_xact_err_keeps: assert property (
		SIE_EV.out_end && SIE_EV.out_crc_err && |OUT_ASSIST_EP
		|=> $stable(OUT_ASSIST_EP))
		else $error("crc error stopped command");
	a_end_clears_runs: assert property (
		SIE_EV.out_end && !SIE_EV.out_crc_err && rx_open
		|=> OUT_ASSIST_EP == '0 && IN_ASSIST_EP == '0)
		else $error("runs not cleared at end");
	a_stall_clears: assert property (
		SIE_EV.out_stalled && OUT_ASSIST_EP[SIE_EV.ep] && |(OUT_ASSIST_EP & EP_FORCE_STALL)
		|=> OUT_ASSIST_EP == '0 && IN_ASSIST_EP == '0)
		else $error("runs not cleared at stall");
	a_ack_swaps_run: assert property (
		SIE_EV.in_acked && |IN_ASSIST_EP
		|=> IN_ASSIST_EP == '0 && |OUT_ASSIST_EP)
		else $error("ack did not swap runs");
	a_noack_both_run: assert property (
		SIE_EV.in_no_ack && |IN_ASSIST_EP
		|=> $stable(IN_ASSIST_EP) && |OUT_ASSIST_EP)
		else $error("no ack did not keep both");
	a_tx_answers: assert property (
		SIE_EV.in_token && IN_ASSIST_EP[SIE_EV.ep] && !IN_TX.valid
		|=> IN_TX.valid)
		else $error("token not answered");
	a_tx_holds: assert property (IN_TX.valid && !SIE_EV.in_byte_taken |=> $stable(IN_TX))
		else $error("byte changed untaken");
	a_tx_last_ends: assert property (
		IN_TX.valid && IN_TX.last && SIE_EV.in_byte_taken
		|=> !IN_TX.valid)
		else $error("valid after last byte");
	c_cmd_end: cover property (SIE_EV.out_end && |OUT_ASSIST_EP);
	c_no_ack: cover property (SIE_EV.in_no_ack && |IN_ASSIST_EP);
	c_stall: cover property (SIE_EV.out_stalled && |EP_FORCE_STALL);
endmodule // bwa_asserts
bind bwa_wrapper_assist bwa_asserts u_bwa_asserts (.CLK_SYS, .ARST_N, .PSEL, .PENABLE, .PREADY,
	.PSLVERR, .SIE_EV, .EP_FORCE_STALL, .OUT_ASSIST_EP, .IN_ASSIST_EP, .IN_TX);
`default_nettype wire

// *** testbench/bwa_host_model.sv ***
// Host and USB engine model: OUT packets and IN status reads on endpoint a.
// Assumes the assist clock; changes its events just after rising edges.
`timescale 1ns/10ps
`default_nettype none
module bwa_host_model (
	input wire logic clk,
	output bwa_pkg::bwa_sie_t sie,
	input wire bwa_pkg::bwa_tx_t tx
);
	import bwa_pkg::*;
	logic [7:0] got [13];
	int last_at;
	initial begin
		sie = '0;
	end
	// Idle data lines flip so a stale byte is never mistaken for data
	task automatic put(input bwa_sie_t e);
		@(posedge clk);
		if (!e.out_byte) begin
			e.out_data = ~sie.out_data;
		end
		sie <= e;
	endtask
	task automatic out_pkt(input int n, input logic crc, input logic stl);
		bwa_sie_t e;
		e = '0;
		e.out_start = 1'b1;
		put(e);
		for (int k = 0; k < n; k++) begin
			e = '0;
			e.out_byte = 1'b1;
			e.out_data = 8'(8'h10 + k);
			put(e);
		end
		e = '0;
		e.out_end = !stl;
		e.out_stalled = stl;
		e.out_crc_err = crc;
		put(e);
		put('0);
	endtask
	// Takes offered bytes and notes the one marked last, then a quiet cycle before the handshake
	task automatic in_xact(input logic ack);
		bwa_sie_t e;
		int k;
		e = '0;
		e.in_token = 1'b1;
		put(e);
		k = 0;
		last_at = -1;
		e = '0;
		for (int c = 0; c < 40 && k < 13; c++) begin
			@(posedge clk);
			if (sie.in_byte_taken && tx.valid) begin
				got[k] = tx.data;
				if (tx.last) begin
					last_at = k;
				end
				k++;
			end
			e.in_byte_taken = (k < 13);
			e.out_data = ~sie.out_data;
			sie <= e;
		end
		e = '0;
		e.in_acked = ack;
		e.in_no_ack = !ack;
		put(e);
		put('0);
	endtask
endmodule // bwa_host_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// Bench for the wrapper assist: APB register tasks and host model traffic.
// Assumes command and status both use endpoint a.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import bwa_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, ev_req, err;
	logic [NUM_EP-1:0] stall = 5'h00;
	logic [NUM_EP-1:0] out_ep, in_ep;
	bwa_sie_t sie;
	bwa_tx_t tx;
	int error_cnt = 0;
	int n_compared = 0;
	int n_tab [6] = '{31, 30, 32, 40, 0, 31};
	logic [5:0] f_tab [6] = '{6'h08, 6'h02, 6'h02, 6'h02, 6'h04, 6'h01};
	initial begin
		forever #2.5 clk = ~clk;
	end
	bwa_wrapper_assist u_bwa_wrapper_assist (.CLK_SYS(clk), .ARST_N(arst_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .SIE_EV(sie), .EP_FORCE_STALL(stall),
		.OUT_ASSIST_EP(out_ep), .IN_ASSIST_EP(in_ep), .IN_TX(tx), .WRAPPER_EVENT_REQ(ev_req));
	bwa_host_model u_host (.clk(clk), .sie(sie), .tx(tx));
	task automatic complete_run;
		$display("Compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (int i = 0; i < 20; i++) begin
			@(posedge clk);
			if (pready) begin
				rd = prdata;
				err = pslverr;
				psel <= 1'b0;
				penable <= 1'b0;
				return;
			end
		end
		error_cnt++;
		complete_run();
	endtask
	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(what, exp, rd);
	endtask
	task automatic sync;
		repeat (3) @(posedge clk);
	endtask
	task automatic in_chk(input logic ack);
		u_host.in_xact(ack);
		for (int k = 0; k < 13; k++) begin
			chk("status byte", 32'h0000_00A0 + 32'(k), 32'(u_host.got[k]));
		end
		chk("last index", 32'h0000_000C, 32'(u_host.last_at));
		sync();
	endtask
	initial begin
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		rdc("config", OFS_CONFIG, 32'h0000_0000);
		rdc("flags", OFS_FLAGS, 32'h0000_0000);
		rdc("unmapped", 8'hF0, 32'h0000_0000);
		chk("slverr", 32'h0000_0001, {31'h0000_0000, err});
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, OFS_RAM_INDEX, 32'(i));
			apb(1'b1, OFS_STATUS_RAM, 32'hA3A2_A1A0 + 32'(i) * 32'h0404_0404);
		end
		rdc("status ram", OFS_STATUS_RAM, 32'hAFAE_ADAC);
		// Only endpoint a is armed, for command and status alike
		apb(1'b1, OFS_CONFIG, 32'h0000_0001);
		apb(1'b1, OFS_FLAG_EN, 32'h0000_003F);
		rdc("flag en", OFS_FLAG_EN, 32'h0000_003F);
		for (int t = 0; t < 6; t++) begin
			apb(1'b1, OFS_CONTROL, 32'h0000_0003);
			stall <= {4'h0, t == 4};
			u_host.out_pkt(n_tab[t], t == 0, t == 4);
			sync();
			chk("out assist", {31'h0000_0000, t == 0}, 32'(out_ep));
			chk("in assist", {31'h0000_0000, t == 0}, 32'(in_ep));
			rdc("flags", OFS_FLAGS, 32'(f_tab[t]));
			chk("event req", 32'h0000_0001, 32'(ev_req));
			apb(1'b1, OFS_FLAGS, 32'(f_tab[t]));
		end
		sync();
		chk("event req", 32'h0000_0000, 32'(ev_req));
		for (int j = 0; j < 7; j++) begin
			apb(1'b1, OFS_RAM_INDEX, 32'(j));
			rdc("cmd ram", OFS_CMD_RAM, 32'h1312_1110 + 32'(j) * 32'h0404_0404);
		end
		apb(1'b1, OFS_CONTROL, 32'h0000_0002);
		in_chk(1'b1);
		chk("in assist", 32'h0000_0000, 32'(in_ep));
		chk("out assist", 32'h0000_0001, 32'(out_ep));
		rdc("flags", OFS_FLAGS, 32'h0000_0010);
		rdc("control", OFS_CONTROL, 32'h0000_0001);
		apb(1'b1, OFS_FLAGS, 32'h0000_0010);
		apb(1'b1, OFS_CONTROL, 32'h0000_0002);
		in_chk(1'b0);
		chk("in assist", 32'h0000_0001, 32'(in_ep));
		chk("out assist", 32'h0000_0001, 32'(out_ep));
		rdc("flags", OFS_FLAGS, 32'h0000_0020);
		apb(1'b1, OFS_FLAGS, 32'h0000_0020);
		in_chk(1'b0);
		u_host.out_pkt(31, 1'b0, 1'b0);
		sync();
		chk("in assist", 32'h0000_0000, 32'(in_ep));
		chk("out assist", 32'h0000_0000, 32'(out_ep));
		rdc("flags", OFS_FLAGS, 32'h0000_0021);
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
